// ===== design/dmcw_pkg.sv
// constants for the drive control word follower over serial RTU framing
// assumes a 10 MHz system clock and an external half-duplex line transceiver
package dmcw_pkg;

  localparam int          CLK_HZ        = 10_000_000;
  localparam int          SILENCE_BITS  = 39;          // 3.5 chars of 11 bits, rounded up
  // register map
  localparam logic [15:0] CTRL_ADDR     = 16'h8000;
  localparam logic [15:0] PRESET_ADDR   = 16'h0000;
  localparam logic [15:0] READ_ONE_REG  = 16'h0001;
  // function and exception codes
  localparam logic [7:0]  FN_READ       = 8'h03;
  localparam logic [7:0]  FN_WR_SAVE    = 8'h06;
  localparam logic [7:0]  FN_WR_VOLAT   = 8'h41;
  localparam logic [7:0]  EXC_FLAG      = 8'h80;
  localparam logic [7:0]  NO_EXC        = 8'h00;
  localparam logic [7:0]  EXC_FUNC      = 8'h01;
  localparam logic [7:0]  EXC_REG       = 8'h02;
  localparam logic [7:0]  EXC_DATA      = 8'h03;
  localparam logic [7:0]  RD_BYTE_CNT   = 8'h02;
  // follower addressing
  localparam logic [7:0]  BCAST_ADDR    = 8'h00;
  localparam logic [7:0]  ADDR_MIN      = 8'h01;
  localparam logic [7:0]  ADDR_MAX      = 8'hF7;
  // frame check
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE   = 16'h0000;
  // frame lengths in bytes, check excluded for replies, then bit counts within a byte
  localparam logic [3:0]  REQ_LEN       = 4'h8;
  localparam logic [3:0]  RD_RSP_LEN    = 4'h5;
  localparam logic [3:0]  ECHO_LEN      = 4'h6;
  localparam logic [3:0]  EXC_LEN       = 4'h3;
  localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
  localparam logic [3:0]  BYTE_DONE     = 4'h9;
  // control word layout
  localparam int          CTRL_W        = 9;
  localparam logic [8:0]  CTRL_RESET    = 9'h000;
  localparam int          RUN_BIT       = 0;
  localparam int          DIR_BIT       = 1;
  localparam int          DECEL_BIT     = 2;
  localparam int          ESTOP_BIT     = 3;
  localparam int          COAST_BIT     = 4;
  localparam int          FLTSTOP_BIT   = 5;
  localparam int          JOGF_BIT      = 6;
  localparam int          JOGR_BIT      = 7;
  localparam int          FRST_BIT      = 8;

endpackage

// ===== design/dmcw_crc_step.sv
// one byte step of the reflected crc16 frame check
// assumes nothing: purely combinational
`timescale 1ns/1ps
module dmcw_crc_step (
  // running value and byte
  input  wire logic [15:0] crc_i,
  input  wire logic [7:0]  byte_i,
  // updated value
  output logic      [15:0] crc_o
);
  always_comb
  begin
    logic [15:0] c;
    c = crc_i ^ {8'h00, byte_i};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ dmcw_pkg::CRC_POLY) : (c >> 1);
    end
    crc_o = c;
  end
endmodule

// ===== design/dmcw_follower.sv
// serial rtu follower that decodes the drive run control word
// assumes a half-duplex transceiver on rxd/txd/de and a static follower address
//
// Behaviour
// - control word lives at register 0x8000, host writes it
// - bit0 set makes the run command valid
// - bit1 selects forward (0) or reverse (1)
// - bit2 requests stop by deceleration
// - bit3 requests emergency stop
// - bit4 requests coasting stop
// - bit5 enables stop on fault
// - bit6 enables forward jog
// - bit7 enables reverse jog
// - bit8 issues fault reset
// - single write to 0x8000 is answered with an echo of the request
// - read of one register answers byte count 2 and the value
// - check starts 0xffff, xor byte, eight shifts with 0xa001
// - high and low check bytes exchanged when sent
// - address 0 is broadcast, 1 to 247 valid, rest reserved
// - failed request answers function plus 0x80 and a cause code
// - bits go lsb first, high byte of a field first
// - write accepted as 0x06 with save and 0x41 without
`timescale 1ns/1ps
module dmcw_follower #(
  parameter int BAUD        = 9600,
  parameter int SILENCE_CYC = dmcw_pkg::SILENCE_BITS * (dmcw_pkg::CLK_HZ / BAUD)
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // serial line
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             de_o,
  // configuration and readback
  input  wire logic [7:0]  own_addr_i,
  input  wire logic [15:0] preset_i,
  // drive commands
  output logic             run_o,
  output logic             reverse_o,
  output logic             decel_stop_o,
  output logic             estop_o,
  output logic             coast_stop_o,
  output logic             fault_stop_en_o,
  output logic             jog_fwd_o,
  output logic             jog_rev_o,
  output logic             fault_reset_o,
  output logic             save_o
);
  localparam int          BIT_CYC = dmcw_pkg::CLK_HZ / BAUD;
  localparam logic [15:0] BITR    = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF    = 16'(BIT_CYC / 2 - 1);
  localparam logic [16:0] SIL_END = 17'(SILENCE_CYC - 1);

  if (BIT_CYC < 8 || BIT_CYC > 65536 || SILENCE_CYC < 2 || SILENCE_CYC > 131071)
  begin : g_bad
    $error("dmcw_follower: baud or silence count out of range");
  end

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } dmcw_rx_t;

  typedef struct packed {
    logic                   s1;
    logic                   s2;
    dmcw_rx_t               rx;
    logic [15:0]            tmr;
    logic [3:0]             bitn;
    logic [7:0]             sh;
    logic [3:0]             nb;
    logic                   ovf;
    logic [7:0][7:0]        rbuf;
    logic [15:0]            crc;
    logic [16:0]            sil;
    logic                   tx_on;
    logic [8:0]             tsh;
    logic [3:0]             tlen;
    logic [3:0]             tidx;
    logic [7:0][7:0]        tbuf;
    logic                   txd;
    logic                   de;
    logic [dmcw_pkg::CTRL_W-1:0] ctrl;
    logic                   save;
  } dmcw_state_t;

  dmcw_state_t q_q;
  dmcw_state_t q_d;

  logic [7:0]  a_addr;
  logic [7:0]  fn;
  logic [15:0] reg_a;
  logic [15:0] val;
  logic        own_ok;
  logic        fend;
  logic        good;
  logic        is_rd;
  logic        is_wr;
  logic        wr_ok;
  logic [7:0]  exc_code;
  logic [15:0] rd_val;
  logic [7:0]  crc_byte;
  logic [15:0] crc_nx;

  // high byte of each field first
  assign a_addr = q_q.rbuf[0];
  assign fn     = q_q.rbuf[1];
  assign reg_a  = {q_q.rbuf[2], q_q.rbuf[3]};
  assign val    = {q_q.rbuf[4], q_q.rbuf[5]};
  assign own_ok = own_addr_i >= dmcw_pkg::ADDR_MIN && own_addr_i <= dmcw_pkg::ADDR_MAX;
  assign fend   = !q_q.tx_on && q_q.rx == RX_IDLE && q_q.nb != 4'h0 && q_q.sil == SIL_END;
  // residue over data and check is zero for an intact frame
  assign good   = fend && q_q.nb == dmcw_pkg::REQ_LEN && !q_q.ovf
                  && q_q.crc == dmcw_pkg::CRC_RESIDUE && own_ok
                  && (a_addr == own_addr_i || a_addr == dmcw_pkg::BCAST_ADDR);
  assign is_rd  = fn == dmcw_pkg::FN_READ;
  assign is_wr  = fn == dmcw_pkg::FN_WR_SAVE || fn == dmcw_pkg::FN_WR_VOLAT;
  // only the control word is writable
  assign wr_ok  = good && is_wr && reg_a == dmcw_pkg::CTRL_ADDR;
  assign exc_code = (!is_rd && !is_wr) ? dmcw_pkg::EXC_FUNC
                  : (is_rd && val != dmcw_pkg::READ_ONE_REG) ? dmcw_pkg::EXC_DATA
                  : (reg_a == dmcw_pkg::CTRL_ADDR
                     || (is_rd && reg_a == dmcw_pkg::PRESET_ADDR)) ? dmcw_pkg::NO_EXC
                  : dmcw_pkg::EXC_REG;
  // upper control bits read as zero
  assign rd_val   = (reg_a == dmcw_pkg::CTRL_ADDR) ? 16'(q_q.ctrl) : preset_i;
  assign crc_byte = q_q.tx_on ? q_q.tbuf[q_q.tidx[2:0]] : q_q.sh;

  dmcw_crc_step u_crc (
    .crc_i  (q_q.crc),
    .byte_i (crc_byte),
    .crc_o  (crc_nx)
  );

  always_comb
  begin
    q_d      = q_q;
    q_d.s1   = rxd_i;
    q_d.s2   = q_q.s1;
    q_d.save = 1'b0;
    if (!q_q.tx_on)
    begin
      case (q_q.rx)
        RX_IDLE:
        begin
          if (!q_q.s2)
          begin
            q_d.rx  = RX_START;
            q_d.tmr = HALF;
          end
        end
        RX_START:
        begin
          if (q_q.tmr == 16'h0000)
          begin
            q_d.rx   = q_q.s2 ? RX_IDLE : RX_DATA;
            q_d.tmr  = BITR;
            q_d.bitn = 4'h0;
          end
          else
            q_d.tmr = q_q.tmr - 16'h0001;
        end
        RX_DATA:
        begin
          if (q_q.tmr == 16'h0000)
          begin
            q_d.sh   = {q_q.s2, q_q.sh[7:1]};
            q_d.bitn = q_q.bitn + 4'h1;
            q_d.tmr  = BITR;
            if (q_q.bitn == dmcw_pkg::LAST_DATA_BIT)
              q_d.rx = RX_STOP;
          end
          else
            q_d.tmr = q_q.tmr - 16'h0001;
        end
        RX_STOP:
        begin
          if (q_q.tmr == 16'h0000)
          begin
            q_d.rx  = RX_IDLE;
            q_d.sil = 17'h0_0000;
            if (q_q.s2 && q_q.nb < dmcw_pkg::REQ_LEN)
            begin
              q_d.rbuf[q_q.nb[2:0]] = q_q.sh;
              q_d.crc = crc_nx;
              q_d.nb  = q_q.nb + 4'h1;
            end
            else
            begin
              q_d.ovf = 1'b1;
              q_d.nb  = (q_q.nb == 4'h0) ? 4'h1 : q_q.nb;
            end
          end
          else
            q_d.tmr = q_q.tmr - 16'h0001;
        end
        default: q_d.rx = RX_IDLE;
      endcase
      if (q_q.rx == RX_IDLE && q_q.nb != 4'h0)
        q_d.sil = q_q.sil + 17'h0_0001;
      if (fend)
      begin
        q_d.nb  = 4'h0;
        q_d.ovf = 1'b0;
        q_d.sil = 17'h0_0000;
        q_d.crc = dmcw_pkg::CRC_INIT;
      end
      if (good)
      begin
        q_d.tbuf[0] = a_addr;
        q_d.tbuf[1] = fn;
        if (exc_code != dmcw_pkg::NO_EXC)
        begin
          q_d.tbuf[1] = fn | dmcw_pkg::EXC_FLAG;
          q_d.tbuf[2] = exc_code;
          q_d.tlen    = dmcw_pkg::EXC_LEN;
        end
        else if (is_rd)
        begin
          q_d.tbuf[2] = dmcw_pkg::RD_BYTE_CNT;
          q_d.tbuf[3] = rd_val[15:8];
          q_d.tbuf[4] = rd_val[7:0];
          q_d.tlen    = dmcw_pkg::RD_RSP_LEN;
        end
        else
        begin
          q_d.tbuf[5:2] = q_q.rbuf[5:2];
          q_d.tlen      = dmcw_pkg::ECHO_LEN;
          q_d.ctrl = val[dmcw_pkg::CTRL_W-1:0];
          q_d.save = fn == dmcw_pkg::FN_WR_SAVE;
        end
        if (a_addr != dmcw_pkg::BCAST_ADDR)
        begin
          q_d.tx_on = 1'b1;
          q_d.de    = 1'b1;
          q_d.tidx  = 4'h0;
          q_d.bitn  = dmcw_pkg::BYTE_DONE;
          q_d.tmr   = 16'h0000;
        end
      end
    end
    else if (q_q.tmr != 16'h0000)
      q_d.tmr = q_q.tmr - 16'h0001;
    else if (q_q.bitn != dmcw_pkg::BYTE_DONE)
    begin
      // data bits lsb first, then stop bit from the one fill
      q_d.txd  = q_q.tsh[0];
      q_d.tsh  = {1'b1, q_q.tsh[8:1]};
      q_d.bitn = q_q.bitn + 4'h1;
      q_d.tmr  = BITR;
    end
    else if (q_q.tidx == 4'(q_q.tlen + 4'h2))
    begin
      q_d.tx_on = 1'b0;
      q_d.de    = 1'b0;
      q_d.txd   = 1'b1;
      q_d.crc   = dmcw_pkg::CRC_INIT;
    end
    else
    begin
      q_d.txd  = 1'b0;
      q_d.bitn = 4'h0;
      q_d.tmr  = BITR;
      q_d.tidx = q_q.tidx + 4'h1;
      if (q_q.tidx < q_q.tlen)
      begin
        q_d.tsh = {1'b1, q_q.tbuf[q_q.tidx[2:0]]};
        q_d.crc = crc_nx;
      end
      // swapped check, its high byte is the accumulator low byte
      else if (q_q.tidx == q_q.tlen)
        q_d.tsh = {1'b1, q_q.crc[7:0]};
      else
        q_d.tsh = {1'b1, q_q.crc[15:8]};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      q_q      <= '0;
      q_q.s1   <= 1'b1;
      q_q.s2   <= 1'b1;
      q_q.txd  <= 1'b1;
      q_q.crc  <= dmcw_pkg::CRC_INIT;
      q_q.ctrl <= dmcw_pkg::CTRL_RESET;
    end
    else
      q_q <= q_d;
  end

  assign txd_o           = q_q.txd;
  assign de_o            = q_q.de;
  assign save_o          = q_q.save;
  assign run_o           = q_q.ctrl[dmcw_pkg::RUN_BIT];
  assign reverse_o       = q_q.ctrl[dmcw_pkg::DIR_BIT];
  assign decel_stop_o    = q_q.ctrl[dmcw_pkg::DECEL_BIT];
  assign estop_o         = q_q.ctrl[dmcw_pkg::ESTOP_BIT];
  assign coast_stop_o    = q_q.ctrl[dmcw_pkg::COAST_BIT];
  assign fault_stop_en_o = q_q.ctrl[dmcw_pkg::FLTSTOP_BIT];
  assign jog_fwd_o       = q_q.ctrl[dmcw_pkg::JOGF_BIT];
  assign jog_rev_o       = q_q.ctrl[dmcw_pkg::JOGR_BIT];
  assign fault_reset_o   = q_q.ctrl[dmcw_pkg::FRST_BIT];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence accept_s;
    good && a_addr != dmcw_pkg::BCAST_ADDR;
  endsequence

  ctrl_write_a: assert property (wr_ok |=> q_q.ctrl == $past(val[8:0]))
    else $error("control word not taken from write");
  run_hold_a: assert property (!wr_ok |=> $stable(run_o))
    else $error("run changed without a write");
  dir_bit_a: assert property (wr_ok |=> reverse_o == $past(val[1]))
    else $error("direction not from bit1");
  estop_bit_a: assert property (wr_ok |=> estop_o == $past(val[3])
    && fault_reset_o == $past(val[8]))
    else $error("stop or reset bit wrong");
  echo_len_a: assert property (accept_s ##0 wr_ok |=> q_q.tx_on && q_q.tlen == 4'h6)
    else $error("write echo not started");
  read_cnt_a: assert property (accept_s ##0 (is_rd && exc_code == 8'h00)
    |=> q_q.tbuf[2] == 8'h02 && q_q.tlen == 4'h5)
    else $error("read reply malformed");
  exc_flag_a: assert property (accept_s ##0 exc_code != 8'h00
    |=> q_q.tbuf[1][7] && q_q.tlen == 4'h3 ##1 q_q.tx_on)
    else $error("exception reply malformed");
  crc_drop_a: assert property ((fend && q_q.crc != 16'h0000) |=> !q_q.tx_on && !de_o)
    else $error("reply to a bad check frame");
  bcast_quiet_a: assert property ((fend && a_addr == 8'h00) |=> !q_q.tx_on [*2])
    else $error("reply to broadcast");
  save_code_a: assert property (save_o |-> $past(wr_ok && fn == 8'h06))
    else $error("save pulse without 0x06 write");
endmodule

// ===== tb/dmcw_host.sv
// serial host model that talks to the drive control follower
// assumes 8 data bits, no parity, one stop bit, BIT_CYC clocks a bit
`timescale 1ns/1ps
module dmcw_host #(
  parameter int BIT_CYC  = 10,
  parameter int WAIT_CYC = 200
) (
  // clock
  input  wire logic clk_i,
  // serial line
  output logic      rxd_o,
  input  wire logic txd_i,
  input  wire logic de_i
);
  initial rxd_o = 1'b1;

  // reflected check, start value and feedback
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i])
    begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction

  // start low, data lsb first, stop high
  task automatic send(input logic [7:0] q[$]);
    logic [9:0] sh;
    foreach (q[i])
    begin
      sh = {1'b1, q[i], 1'b0};
      for (int k = 0; k < 10; k++)
      begin
        rxd_o = sh[k];
        repeat (BIT_CYC) @(negedge clk_i);
      end
    end
  endtask

  // collects reply bytes while the follower drives the line
  task automatic recv(output logic [7:0] q[$]);
    logic [7:0] b;
    int         n;
    q = {};
    n = 0;
    while (de_i !== 1'b1 && n < WAIT_CYC)
    begin
      @(negedge clk_i);
      n++;
    end
    while (de_i === 1'b1)
    begin
      @(negedge clk_i);
      if (txd_i === 1'b0)
      begin
        repeat (BIT_CYC / 2) @(negedge clk_i);
        for (int k = 0; k < 8; k++)
        begin
          repeat (BIT_CYC) @(negedge clk_i);
          b[k] = txd_i;
        end
        q.push_back(b);
        repeat (BIT_CYC) @(negedge clk_i);
      end
    end
  endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the drive control word follower
// assumes a short bit time and silence so the run stays brief
`timescale 1ns/1ps
module tb_top;
  logic        clk_i;
  logic        rst_b_i;
  logic        rxd_i;
  logic        txd_o;
  logic        de_o;
  logic        save_o;
  logic [7:0]  own_addr_i;
  logic [15:0] preset_i;
  logic [8:0]  cmd;
  logic [15:0] ctrl;
  logic [15:0] saves;
  logic [15:0] nsave;
  logic [31:0] w;
  int          fail_count;
  int          compares;

  dmcw_follower #(.BAUD(1_000_000), .SILENCE_CYC(40)) DUT (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .rxd_i(rxd_i), .txd_o(txd_o), .de_o(de_o),
    .own_addr_i(own_addr_i), .preset_i(preset_i), .run_o(cmd[0]), .reverse_o(cmd[1]),
    .decel_stop_o(cmd[2]), .estop_o(cmd[3]), .coast_stop_o(cmd[4]),
    .fault_stop_en_o(cmd[5]), .jog_fwd_o(cmd[6]), .jog_rev_o(cmd[7]),
    .fault_reset_o(cmd[8]), .save_o(save_o));

  dmcw_host #(.BIT_CYC(10), .WAIT_CYC(200)) host (
    .clk_i(clk_i), .rxd_o(rxd_i), .txd_i(txd_o), .de_i(de_o));

  initial clk_i = 1'b0;
  always #50 clk_i = ~clk_i;

  always @(posedge clk_i)
    if (rst_b_i !== 1'b1)
      saves <= 16'h0000;
    else if (save_o === 1'b1)
      saves <= saves + 16'h0001;

  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_frame(input logic [7:0] got[$], input logic [7:0] exp[$]);
    chk_word(16'(got.size()), 16'(exp.size()));
    foreach (exp[i])
      if (i < got.size())
        chk_word({8'h00, got[i]}, {8'h00, exp[i]});
  endtask

  // sends one request and compares reply, commands and save pulses with the model
  task automatic xact(input logic [7:0] adr, fn, input logic [15:0] a, d, input bit bad);
    logic [7:0]  q[$];
    logic [7:0]  e[$];
    logic [7:0]  r[$];
    logic [15:0] c;
    logic [15:0] v;
    q = {adr, fn, a[15:8], a[7:0], d[15:8], d[7:0]};
    c = host.crc16(q);
    q.push_back(c[7:0] ^ {7'h00, bad});
    q.push_back(c[15:8]);
    host.send(q);
    host.recv(r);
    e = {};
    if (!bad && own_addr_i >= 8'h01 && own_addr_i <= 8'hf7
        && (adr == 8'h00 || adr == own_addr_i))
    begin
      if ((fn == 8'h06 || fn == 8'h41) && a == 16'h8000)
      begin
        ctrl = {7'h00, d[8:0]};
        nsave = nsave + {15'h0000, fn == 8'h06};
        e = q;
      end
      else if (fn == 8'h06 || fn == 8'h41)
        e = {adr, fn | 8'h80, 8'h02};
      else if (fn != 8'h03)
        e = {adr, fn | 8'h80, 8'h01};
      else if (a != 16'h8000 && a != 16'h0000)
        e = {adr, fn | 8'h80, 8'h02};
      else if (d != 16'h0001)
        e = {adr, fn | 8'h80, 8'h03};
      else
      begin
        v = a[15] ? ctrl : preset_i;
        e = {adr, fn, 8'h02, v[15:8], v[7:0]};
      end
      c = host.crc16(e);
      if (adr == 8'h00)
        e = {};
      else if (e.size() < 8)
        e = {e, c[7:0], c[15:8]};
    end
    chk_frame(r, e);
    chk_word({7'h00, cmd}, ctrl);
    chk_word(saves, nsave);
  endtask

  initial
  begin
    repeat (80000) @(negedge clk_i);
    fail_count++;
    test_done();
  end

  initial
  begin
    rst_b_i = 1'b0;
    own_addr_i = 8'h01;
    preset_i = 16'h1388;
    ctrl = 16'h0000;
    nsave = 16'h0000;
    fail_count = 0;
    compares = 0;
    void'($urandom(32'hc405));
    repeat (16) @(negedge clk_i);
    chk_word({de_o, txd_o, save_o, 4'h0, cmd}, 16'h4000);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    xact(8'h01, 8'h03, 16'h0000, 16'h0001, 1'b0);
    xact(8'h01, 8'h06, 16'h8000, 16'h0001, 1'b0);
    for (int i = 0; i < 16; i++)
      xact(8'h01, 8'h06, 16'h8000, 16'h0001 << i, 1'b0);
    repeat (4)
    begin
      w = $urandom;
      xact(8'h01, w[16] ? 8'h06 : 8'h41, 16'h8000, w[15:0], 1'b0);
      xact(8'h01, 8'h03, 16'h8000, 16'h0001, 1'b0);
    end
    // mid-run reset must clear a written control word
    rst_b_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk_word({de_o, txd_o, save_o, 4'h0, cmd}, 16'h4000);
    ctrl = 16'h0000;
    nsave = 16'h0000;
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    xact(8'h01, 8'h03, 16'h8000, 16'h0001, 1'b0);
    xact(8'h01, 8'h10, 16'h8000, 16'h0001, 1'b0);
    xact(8'h01, 8'h06, 16'h1234, 16'h0005, 1'b0);
    xact(8'h01, 8'h03, 16'h8000, 16'h0002, 1'b0);
    xact(8'h01, 8'h03, 16'h0005, 16'h0001, 1'b0);
    xact(8'h01, 8'h06, 16'h8000, 16'h01ff, 1'b1);
    xact(8'h02, 8'h06, 16'h8000, 16'h01ff, 1'b0);
    xact(8'h00, 8'h06, 16'h8000, 16'h00aa, 1'b0);
    own_addr_i = 8'hf8;
    xact(8'hf8, 8'h06, 16'h8000, 16'h0003, 1'b0);
    xact(8'h00, 8'h06, 16'h8000, 16'h0005, 1'b0);
    own_addr_i = 8'hf7;
    xact(8'hf7, 8'h41, 16'h8000, 16'h0155, 1'b0);
    own_addr_i = 8'h01;
    xact(8'h01, 8'h03, 16'h8000, 16'h0001, 1'b0);
    test_done();
  end
endmodule
